// [verilog/umap_map.svh]
// Purpose: offsets, fields, reset values and timing of the user io mapper
// Assumes: axi4-lite byte addresses, 125 MHz clock
// Notes: definitions only
//
// Summary of operation
// - analog-driven parameters apply only with analog source; source resets to local
// - absent analog input reads as zero, giving a zero set point
// - standard analog inputs are heavily low-pass filtered before use
// - high-speed input is unfiltered and refreshed every 500 us
// - set point parameters map input range linearly to 0..100% rated
// - trip parameters map input range linearly to 10..110% rated
// - analog-driven parameter ignores stored value and rejects panel and bus writes
// - analog-derived set and trip points stay readable
// - analog outputs report v, i or p from sense leads or terminals
// - each digital input may be assigned any input function
// - stop wins over start when both are requested together
// - enable function enables power while its input is high and no fault is latched
// - interlock input must stay high; its removal trips the device
// - clear-fault removes fault only when the fault condition is gone
// - lock input high blocks front panel keypresses
// - momentary functions fire on a rising edge held at least 3 ms
`ifndef UMAP_MAP_SVH
`define UMAP_MAP_SVH
`define UMAP_CLK_MHZ 125
`define UMAP_HS_PERIOD_US 500
`define UMAP_PULSE_MIN_US 3000
`define UMAP_FILT_SHIFT 6
`define UMAP_TRIP_BASE 17'h0_199A
`define UMAP_OFS_CTRL 8'h00
`define UMAP_OFS_AI_ASG 8'h04
`define UMAP_OFS_AO_SEL 8'h08
`define UMAP_OFS_DI_ASG 8'h0C
`define UMAP_OFS_CMD 8'h10
`define UMAP_OFS_STATUS 8'h14
`define UMAP_OFS_IRQ_STAT 8'h18
`define UMAP_OFS_IRQ_MASK 8'h1C
`define UMAP_OFS_SETPT 8'h20
`define UMAP_OFS_SETPT_END 8'h34
`define UMAP_CTRL_SRC_LSB 0
`define UMAP_CTRL_RSENSE_BIT 4
`define UMAP_CMD_START_BIT 0
`define UMAP_CMD_STOP_BIT 1
`define UMAP_CMD_CLEAR_BIT 2
`define UMAP_IRQ_TRIP_BIT 0
`define UMAP_IRQ_CLEARED_BIT 1
`define UMAP_IRQ_REJECT_BIT 2
`define UMAP_IRQ_STOP_BIT 3
`define UMAP_IRQ_START_BIT 4
`define UMAP_CTRL_RST 32'h0000_0000
`define UMAP_AI_ASG_RST 32'h0000_0008
`define UMAP_AO_SEL_RST 32'h0000_0006
`define UMAP_DI_ASG_RST 32'h0000_0019
`define UMAP_RESP_OKAY 2'h0
`define UMAP_RESP_SLVERR 2'h2
`endif

// [verilog/umap_pkg.sv]
// Purpose: types of the user io mapper
// Assumes: four analog and four digital inputs
// Notes: widths fixed by the connector
package umap_pkg;
	typedef enum logic [1:0] {UMAP_SRC_LOCAL, UMAP_SRC_FGEN, UMAP_SRC_ANALOG,
		UMAP_SRC_SEQ} umap_src_t;
	typedef enum logic [2:0] {UMAP_DI_NONE, UMAP_DI_ENABLE, UMAP_DI_INTERLOCK, UMAP_DI_CLEAR,
		UMAP_DI_LOCK, UMAP_DI_START, UMAP_DI_STOP} umap_difn_t;
	typedef enum logic [1:0] {UMAP_AO_OFF, UMAP_AO_VOLT, UMAP_AO_CURR,
		UMAP_AO_POWER} umap_aosel_t;
	typedef struct packed {
		logic [7:0] awaddr; logic awvalid; logic [31:0] wdata; logic [3:0] wstrb;
		logic wvalid; logic bready; logic [7:0] araddr; logic arvalid; logic rready;
	} umap_axil_req_t;
	typedef struct packed {
		logic awready; logic wready; logic [1:0] bresp; logic bvalid;
		logic arready; logic [31:0] rdata; logic [1:0] rresp; logic rvalid;
	} umap_axil_rsp_t;
	typedef struct packed {
		logic [3:0][15:0] data; logic [3:0] valid; logic [3:0] present;
	} umap_ai_t;
	typedef struct packed {
		logic [2:0][15:0] term; logic [2:0][15:0] sense;
	} umap_meas_t;
	typedef struct packed {
		logic key_valid; logic wr; logic [2:0] wr_idx; logic [16:0] wr_data;
	} umap_panel_t;
	typedef struct packed {
		logic [3:0] sync1; logic [3:0] sync2; logic [3:0][19:0] cnt;
		logic [3:0] armed; logic [3:0] pulse;
	} umap_dq_state_t;
	typedef struct packed {
		logic [1:0] src; logic rsense; logic [5:0][2:0] ai_asg; logic [2:0][1:0] ao_sel;
		logic [3:0][2:0] di_asg; logic [5:0][16:0] stored; logic [5:0][16:0] eff;
		logic [3:0][23:0] filt; logic [15:0] hs; logic [19:0] hs_cnt; logic hs_tick;
		logic [2:0][15:0] ao; logic running; logic fault; logic power_en; logic lock;
		logic [4:0] irq_stat; logic [4:0] irq_mask;
		logic aw_held; logic [7:0] aw_addr; logic w_held; logic [31:0] wdata;
		logic [3:0] wstrb; logic bvalid; logic [1:0] bresp;
		logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
	} umap_state_t;
endpackage : umap_pkg

// [verilog/umap_din_qual.sv]
// Purpose: synchronise digital inputs and qualify momentary edges
// Assumes: inputs asynchronous to clock_i
// Notes: pulse needs the level held PULSE_CYCLES after a rising edge
`timescale 1ns/100ps
module umap_din_qual #(
	parameter int PULSE_CYCLES = 375000
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_b_i,
	// pins and qualified view
	input wire logic [3:0] din_i,
	output logic [3:0] level_o,
	output logic [3:0] pulse_o
);
	localparam logic [19:0] CNT_LAST = 20'(PULSE_CYCLES - 1);
	umap_pkg::umap_dq_state_t st_reg;
	umap_pkg::umap_dq_state_t st_next;

	always_comb begin
		st_next = st_reg;
		st_next.sync1 = din_i;
		st_next.sync2 = st_reg.sync1;
		for (int k = 0; k < 4; k++) begin
			st_next.pulse[k] = 1'b0;
			if (!st_reg.sync2[k]) begin
				st_next.cnt[k] = 20'h0_0000;
				st_next.armed[k] = 1'b1;
			end else if (st_reg.armed[k]) begin
				// short glitches re-arm without firing
				if (st_reg.cnt[k] == CNT_LAST) begin
					st_next.pulse[k] = 1'b1;
					st_next.armed[k] = 1'b0;
				end else begin
					st_next.cnt[k] = st_reg.cnt[k] + 20'h0_0001;
				end
			end
		end
	end

	// armed clear at reset, but sync2 resets low and arms on the first clock: a level already high fires as an edge
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign level_o = st_reg.sync2;
	assign pulse_o = st_reg.pulse;

	////////////////////////////////////////////////////////////////////////////
	property p_short_no_pulse;
		@(posedge clock_i) disable iff (!rst_b_i)
		$rose(st_reg.sync2[0]) ##1 !st_reg.sync2[0] |=> !st_reg.pulse[0];
	endproperty
	a_short_no_pulse: assert property (p_short_no_pulse) else $error("short pulse fired");
	property p_pulse_level;
		@(posedge clock_i) disable iff (!rst_b_i)
		st_reg.pulse[0] |-> $past(st_reg.sync2[0], 2) && $past(st_reg.sync2[0]);
	endproperty
	a_pulse_level: assert property (p_pulse_level) else $error("pulse without level");
endmodule : umap_din_qual

// [verilog/umap_top.sv]
// Purpose: user io function mapper with axi4-lite registers
// Assumes: adc samples and measurements arrive synchronous to clock_i
// Notes: set points are fractions of rating, 17'h1_0000 is 100%
`timescale 1ns/100ps
`include "umap_map.svh"
module umap_top #(
	parameter int HS_CYCLES = `UMAP_HS_PERIOD_US * `UMAP_CLK_MHZ,
	parameter int PULSE_CYCLES = `UMAP_PULSE_MIN_US * `UMAP_CLK_MHZ
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_b_i,
	// register bus
	input wire umap_pkg::umap_axil_req_t axi_req_i,
	output umap_pkg::umap_axil_rsp_t axi_rsp_o,
	// analog side
	input wire umap_pkg::umap_ai_t ai_i,
	input wire umap_pkg::umap_meas_t meas_i,
	output logic [5:0][16:0] setpoints_o,
	output logic [2:0][15:0] ao_o,
	// digital side
	input wire logic [3:0] din_i,
	input wire logic fault_cond_i,
	output logic power_en_o,
	output logic fault_o,
	output logic lock_o,
	// front panel
	input wire umap_pkg::umap_panel_t panel_i,
	output logic panel_key_accept_o,
	output logic irq_o
);
	localparam logic [19:0] HS_LAST = 20'(HS_CYCLES - 1);
	umap_pkg::umap_state_t st_reg;
	umap_pkg::umap_state_t st_next;
	logic [3:0] lvl;
	logic [3:0] pls;
	logic [5:0] driven;
	logic [3:0][15:0] code;
	logic en_asg, en_lvl, ilk_asg, ilk_ok, lock_act, clr_pls, start_pls, stop_pls;
	logic [31:0] ctrl_v, status_v;

	umap_din_qual #(.PULSE_CYCLES(PULSE_CYCLES)) u_qual (
		.clock_i(clock_i),
		.rst_b_i(rst_b_i),
		.din_i(din_i),
		.level_o(lvl),
		.pulse_o(pls)
	);

	////////////////////////////////////////////////////////////////////////////
	function automatic logic [3:0] hits(input logic [3:0][2:0] asg,
		input umap_pkg::umap_difn_t fn);
		for (int k = 0; k < 4; k++) begin
			hits[k] = (umap_pkg::umap_difn_t'(asg[k]) == fn);
		end
	endfunction : hits

	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		for (int b = 0; b < 4; b++) begin
			wmerge[8*b +: 8] = s[b] ? d[8*b +: 8] : old[8*b +: 8];
		end
	endfunction : wmerge

	function automatic logic [16:0] scale_code(input logic [15:0] c, input logic trip);
		scale_code = trip ? {1'b0, c} + `UMAP_TRIP_BASE : {1'b0, c};
	endfunction : scale_code

	// one-pole iir; long time constant trades response for stability
	function automatic logic [23:0] filt_step(input logic [23:0] acc, input logic [15:0] x);
		logic signed [24:0] diff;
		diff = $signed({1'b0, x, 8'h00}) - $signed({1'b0, acc});
		filt_step = acc + 24'(diff >>> `UMAP_FILT_SHIFT);
	endfunction : filt_step

	////////////////////////////////////////////////////////////////////////////
	assign en_asg = |hits(st_reg.di_asg, umap_pkg::UMAP_DI_ENABLE);
	assign en_lvl = |(hits(st_reg.di_asg, umap_pkg::UMAP_DI_ENABLE) & lvl);
	assign ilk_asg = |hits(st_reg.di_asg, umap_pkg::UMAP_DI_INTERLOCK);
	assign ilk_ok = &(~hits(st_reg.di_asg, umap_pkg::UMAP_DI_INTERLOCK) | lvl);
	assign lock_act = |(hits(st_reg.di_asg, umap_pkg::UMAP_DI_LOCK) & lvl);
	assign clr_pls = |(hits(st_reg.di_asg, umap_pkg::UMAP_DI_CLEAR) & pls);
	assign start_pls = |(hits(st_reg.di_asg, umap_pkg::UMAP_DI_START) & pls);
	assign stop_pls = |(hits(st_reg.di_asg, umap_pkg::UMAP_DI_STOP) & pls);
	assign code[0] = st_reg.filt[0][23:8];
	assign code[1] = st_reg.hs;
	assign code[2] = st_reg.filt[2][23:8];
	assign code[3] = st_reg.filt[3][23:8];
	assign ctrl_v = (32'(st_reg.src) << `UMAP_CTRL_SRC_LSB)
		| (32'(st_reg.rsense) << `UMAP_CTRL_RSENSE_BIT);
	assign status_v = {26'h000_0000, fault_cond_i, st_reg.lock, ilk_ok, st_reg.fault,
		st_reg.power_en, st_reg.running};
	always_comb begin
		for (int k = 0; k < 6; k++) begin
			driven[k] = (umap_pkg::umap_src_t'(st_reg.src) == umap_pkg::UMAP_SRC_ANALOG)
				&& (st_reg.ai_asg[k] != 3'h0) && (st_reg.ai_asg[k] <= 3'h4);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic [31:0] nv;
		logic [2:0] idx;
		logic [15:0] smp;
		logic [2:0][15:0] m;
		logic sw_start, sw_stop, sw_clr, reject, clr_ok, trip, start_req, stop_req;
		logic [4:0] w1c, ev;
		nv = 32'h0000_0000;
		idx = 3'h0;
		smp = 16'h0000;
		m = '0;
		sw_start = 1'b0;
		sw_stop = 1'b0;
		sw_clr = 1'b0;
		reject = 1'b0;
		w1c = 5'h00;
		ev = 5'h00;
		trip = 1'b0;
		clr_ok = 1'b0;
		start_req = 1'b0;
		stop_req = 1'b0;
		st_next = st_reg;
		// write channel: address and data taken in either order
		if (axi_req_i.awvalid && !st_reg.aw_held && !st_reg.bvalid) begin
			st_next.aw_held = 1'b1;
			st_next.aw_addr = axi_req_i.awaddr;
		end
		if (axi_req_i.wvalid && !st_reg.w_held && !st_reg.bvalid) begin
			st_next.w_held = 1'b1;
			st_next.wdata = axi_req_i.wdata;
			st_next.wstrb = axi_req_i.wstrb;
		end
		if (st_reg.bvalid && axi_req_i.bready) begin
			st_next.bvalid = 1'b0;
		end
		if (st_reg.aw_held && st_reg.w_held && !st_reg.bvalid) begin
			st_next.aw_held = 1'b0;
			st_next.w_held = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = `UMAP_RESP_OKAY;
			unique case (st_reg.aw_addr)
				`UMAP_OFS_CTRL: begin
					nv = wmerge(ctrl_v, st_reg.wdata, st_reg.wstrb);
					st_next.src = nv[`UMAP_CTRL_SRC_LSB +: 2];
					st_next.rsense = nv[`UMAP_CTRL_RSENSE_BIT];
				end
				`UMAP_OFS_AI_ASG: begin
					nv = wmerge(32'(st_reg.ai_asg), st_reg.wdata, st_reg.wstrb);
					st_next.ai_asg = nv[17:0];
				end
				`UMAP_OFS_AO_SEL: begin
					nv = wmerge(32'(st_reg.ao_sel), st_reg.wdata, st_reg.wstrb);
					st_next.ao_sel = nv[5:0];
				end
				`UMAP_OFS_DI_ASG: begin
					nv = wmerge(32'(st_reg.di_asg), st_reg.wdata, st_reg.wstrb);
					st_next.di_asg = nv[11:0];
				end
				`UMAP_OFS_CMD: begin
					sw_start = st_reg.wstrb[0] && st_reg.wdata[`UMAP_CMD_START_BIT];
					sw_stop = st_reg.wstrb[0] && st_reg.wdata[`UMAP_CMD_STOP_BIT];
					sw_clr = st_reg.wstrb[0] && st_reg.wdata[`UMAP_CMD_CLEAR_BIT];
				end
				`UMAP_OFS_STATUS: begin
				end
				`UMAP_OFS_IRQ_STAT: begin
					w1c = st_reg.wstrb[0] ? st_reg.wdata[4:0] : 5'h00;
				end
				`UMAP_OFS_IRQ_MASK: begin
					nv = wmerge(32'(st_reg.irq_mask), st_reg.wdata, st_reg.wstrb);
					st_next.irq_mask = nv[4:0];
				end
				default: begin
					if (st_reg.aw_addr >= `UMAP_OFS_SETPT && st_reg.aw_addr <= `UMAP_OFS_SETPT_END
						&& st_reg.aw_addr[1:0] == 2'b00) begin
						idx = 3'((st_reg.aw_addr - `UMAP_OFS_SETPT) >> 2);
						if (driven[idx]) begin
							reject = 1'b1;
							st_next.bresp = `UMAP_RESP_SLVERR;
						end else begin
							nv = wmerge(32'(st_reg.stored[idx]), st_reg.wdata, st_reg.wstrb);
							st_next.stored[idx] = nv[16:0];
						end
					end else begin
						st_next.bresp = `UMAP_RESP_SLVERR;
					end
				end
			endcase
		end
		// front panel writes: refused when analog-driven or locked
		if (panel_i.wr && panel_i.wr_idx <= 3'h5) begin
			if (driven[panel_i.wr_idx] || lock_act) begin
				reject = 1'b1;
			end else begin
				st_next.stored[panel_i.wr_idx] = panel_i.wr_data;
			end
		end
		// read channel
		if (st_reg.rvalid && axi_req_i.rready) begin
			st_next.rvalid = 1'b0;
		end
		if (axi_req_i.arvalid && !st_reg.rvalid) begin
			st_next.rvalid = 1'b1;
			st_next.rresp = `UMAP_RESP_OKAY;
			unique case (axi_req_i.araddr)
				`UMAP_OFS_CTRL: st_next.rdata = ctrl_v;
				`UMAP_OFS_AI_ASG: st_next.rdata = 32'(st_reg.ai_asg);
				`UMAP_OFS_AO_SEL: st_next.rdata = 32'(st_reg.ao_sel);
				`UMAP_OFS_DI_ASG: st_next.rdata = 32'(st_reg.di_asg);
				`UMAP_OFS_CMD: st_next.rdata = 32'h0000_0000;
				`UMAP_OFS_STATUS: st_next.rdata = status_v;
				`UMAP_OFS_IRQ_STAT: st_next.rdata = 32'(st_reg.irq_stat);
				`UMAP_OFS_IRQ_MASK: st_next.rdata = 32'(st_reg.irq_mask);
				default: begin
					st_next.rdata = 32'h0000_0000;
					if (axi_req_i.araddr >= `UMAP_OFS_SETPT
						&& axi_req_i.araddr <= `UMAP_OFS_SETPT_END
						&& axi_req_i.araddr[1:0] == 2'b00) begin
						idx = 3'((axi_req_i.araddr - `UMAP_OFS_SETPT) >> 2);
						st_next.rdata = 32'(st_reg.eff[idx]);
					end else begin
						st_next.rresp = `UMAP_RESP_SLVERR;
					end
				end
			endcase
		end
		// analog inputs
		for (int k = 0; k < 4; k++) begin
			smp = ai_i.present[k] ? ai_i.data[k] : 16'h0000;
			if (k != 1 && ai_i.valid[k]) begin
				st_next.filt[k] = filt_step(st_reg.filt[k], smp);
			end
		end
		st_next.hs_tick = (st_reg.hs_cnt == HS_LAST);
		st_next.hs_cnt = st_next.hs_tick ? 20'h0_0000 : st_reg.hs_cnt + 20'h0_0001;
		if (st_reg.hs_tick) begin
			st_next.hs = ai_i.present[1] ? ai_i.data[1] : 16'h0000;
		end
		for (int k = 0; k < 6; k++) begin
			st_next.eff[k] = driven[k]
				? scale_code(code[2'(st_reg.ai_asg[k] - 3'h1)], k >= 3)
				: st_reg.stored[k];
		end
		m = st_reg.rsense ? meas_i.sense : meas_i.term;
		for (int j = 0; j < 3; j++) begin
			unique case (umap_pkg::umap_aosel_t'(st_reg.ao_sel[j]))
				umap_pkg::UMAP_AO_OFF: st_next.ao[j] = 16'h0000;
				umap_pkg::UMAP_AO_VOLT: st_next.ao[j] = m[0];
				umap_pkg::UMAP_AO_CURR: st_next.ao[j] = m[1];
				umap_pkg::UMAP_AO_POWER: st_next.ao[j] = m[2];
			endcase
		end
		// run, fault and enable
		start_req = sw_start || start_pls;
		stop_req = sw_stop || stop_pls;
		if (stop_req) begin
			st_next.running = 1'b0;
		end else if (start_req) begin
			st_next.running = 1'b1;
		end
		trip = ilk_asg && !ilk_ok;
		clr_ok = (sw_clr || clr_pls) && !fault_cond_i && !trip;
		st_next.fault = (st_reg.fault && !clr_ok) || trip;
		st_next.power_en = (en_asg ? en_lvl : st_reg.running) && !st_reg.fault;
		st_next.lock = lock_act;
		ev[`UMAP_IRQ_TRIP_BIT] = trip && !st_reg.fault;
		ev[`UMAP_IRQ_CLEARED_BIT] = clr_ok && st_reg.fault;
		ev[`UMAP_IRQ_REJECT_BIT] = reject;
		ev[`UMAP_IRQ_STOP_BIT] = stop_req;
		ev[`UMAP_IRQ_START_BIT] = start_req && !stop_req;
		// a new event beats a same-cycle clear
		st_next.irq_stat = (st_reg.irq_stat & ~w1c) | ev;
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_reg <= '0;
			st_reg.src <= 2'(`UMAP_CTRL_RST >> `UMAP_CTRL_SRC_LSB);
			st_reg.ai_asg <= 18'(`UMAP_AI_ASG_RST);
			st_reg.ao_sel <= 6'(`UMAP_AO_SEL_RST);
			st_reg.di_asg <= 12'(`UMAP_DI_ASG_RST);
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	assign axi_rsp_o.awready = !st_reg.aw_held && !st_reg.bvalid;
	assign axi_rsp_o.wready = !st_reg.w_held && !st_reg.bvalid;
	assign axi_rsp_o.bvalid = st_reg.bvalid;
	assign axi_rsp_o.bresp = st_reg.bresp;
	assign axi_rsp_o.arready = !st_reg.rvalid;
	assign axi_rsp_o.rvalid = st_reg.rvalid;
	assign axi_rsp_o.rdata = st_reg.rdata;
	assign axi_rsp_o.rresp = st_reg.rresp;
	assign setpoints_o = st_reg.eff;
	assign ao_o = st_reg.ao;
	assign power_en_o = st_reg.power_en;
	assign fault_o = st_reg.fault;
	assign lock_o = st_reg.lock;
	assign panel_key_accept_o = panel_i.key_valid && !lock_act;
	assign irq_o = |(st_reg.irq_stat & st_reg.irq_mask);

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);
	property p_src_gate;
		!driven[0] |=> st_reg.eff[0] == $past(st_reg.stored[0]);
	endproperty
	a_src_gate: assert property (p_src_gate) else $error("undriven set point not stored");
	property p_hs_hold;
		!st_reg.hs_tick |=> $stable(st_reg.hs);
	endproperty
	a_hs_hold: assert property (p_hs_hold) else $error("fast input moved off tick");
	property p_trip_floor;
		driven[3] ##1 1'b1 |-> st_reg.eff[3] >= `UMAP_TRIP_BASE;
	endproperty
	a_trip_floor: assert property (p_trip_floor) else $error("trip below ten percent");
	property p_panel_reject;
		panel_i.wr && panel_i.wr_idx == 3'h0 && driven[0] |=> st_reg.irq_stat[2]
			&& $stable(st_reg.stored[0]);
	endproperty
	a_panel_reject: assert property (p_panel_reject) else $error("driven write taken");
	property p_stop_wins;
		stop_pls && start_pls |=> !st_reg.running;
	endproperty
	a_stop_wins: assert property (p_stop_wins) else $error("start beat stop");
	property p_enable_level;
		en_asg && !st_reg.fault |=> power_en_o == $past(en_lvl);
	endproperty
	a_enable_level: assert property (p_enable_level) else $error("enable not level");
	property p_interlock_trip;
		ilk_asg && !ilk_ok |=> fault_o [*2];
	endproperty
	a_interlock_trip: assert property (p_interlock_trip) else $error("no interlock fault");
	property p_clear_blocked;
		fault_o && fault_cond_i |=> fault_o;
	endproperty
	a_clear_blocked: assert property (p_clear_blocked) else $error("fault cleared early");
	property p_lock_keys;
		lock_act |-> !panel_key_accept_o;
	endproperty
	a_lock_keys: assert property (p_lock_keys) else $error("key passed while locked");
	c_trip: cover property (ilk_asg ##1 !ilk_ok ##1 fault_o);
	c_clear: cover property (fault_o ##1 !fault_o);
	c_run: cover property (!st_reg.running ##1 st_reg.running);
	c_write: cover property (axi_rsp_o.bvalid && axi_req_i.bready);
endmodule : umap_top

// [tb/umap_ctl_model.sv]
// Purpose: far-side controller driving the four digital pins
// Assumes: dry contacts, open pins read low
// Notes: hold times counted in device clock cycles
`timescale 1ns/100ps
module umap_ctl_model (
	// clock
	input wire logic clock_i,
	// pins
	output logic [3:0] din_o
);
	initial din_o = 4'h0;
	////////////////////////////////////////////////////////////////////////
	task automatic level(input int i, input logic v);
		@(posedge clock_i) din_o[i] <= v;
	endtask : level
	// short holds probe the edge filter, long ones count
	task automatic pulse(input int i, input int n);
		@(posedge clock_i) din_o[i] <= 1'b1;
		repeat (n) @(posedge clock_i);
		din_o[i] <= 1'b0;
		repeat (4) @(posedge clock_i);
	endtask : pulse
endmodule : umap_ctl_model

// [tb/tb_top.sv]
// Purpose: self-checking bench of the user io mapper
// Assumes: short tick and pulse parameters keep the run brief
// Notes: reset values run from a table, the rest by hand
`timescale 1ns/100ps
module tb_top;
	typedef struct packed {logic [7:0] a; logic [31:0] d; logic [1:0] r;} umap_row_t;
	logic clock_i, rst_b_i, fault_cond_i, power_en_o, fault_o, lock_o, key_ok, irq_o;
	umap_pkg::umap_axil_req_t rq;
	umap_pkg::umap_axil_rsp_t rs;
	umap_pkg::umap_ai_t ai;
	umap_pkg::umap_meas_t ms;
	umap_pkg::umap_panel_t pn;
	logic [5:0][16:0] sp;
	logic [2:0][15:0] ao;
	logic [3:0] din;
	logic [31:0] d;
	logic [1:0] rp;
	int num_errors = 0;
	int check_count = 0;
	umap_row_t rows [7] = '{'{8'h00, 32'h0, 2'h0}, '{8'h04, 32'h8, 2'h0},
		'{8'h08, 32'h6, 2'h0}, '{8'h0C, 32'h19, 2'h0}, '{8'h1C, 32'h0, 2'h0},
		'{8'h40, 32'h0, 2'h2}, '{8'h02, 32'h0, 2'h2}};
	umap_ctl_model ctl_u (.clock_i(clock_i), .din_o(din));
	umap_top #(.HS_CYCLES(16), .PULSE_CYCLES(8)) dut_u (.clock_i(clock_i), .rst_b_i(rst_b_i),
		.axi_req_i(rq), .axi_rsp_o(rs), .ai_i(ai), .meas_i(ms), .setpoints_o(sp), .ao_o(ao),
		.din_i(din), .fault_cond_i(fault_cond_i), .power_en_o(power_en_o), .fault_o(fault_o),
		.lock_o(lock_o), .panel_i(pn), .panel_key_accept_o(key_ok), .irq_o(irq_o));
	initial begin
		clock_i = 1'b0;
		forever #4 clock_i = ~clock_i;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [127:0] s, input logic [127:0] x);
		check_count++;
		if (s !== x) begin
			num_errors++;
			$display("[ERR] %0t seen %0h expected %0h", $time, s, x);
		end
	endtask : chk
	task automatic conclude();
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : conclude
	// address and data offered together, each released once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
		int n;
		@(posedge clock_i);
		rq.awaddr <= a;
		rq.wdata <= v;
		rq.wstrb <= 4'hF;
		rq.awvalid <= 1'b1;
		rq.wvalid <= 1'b1;
		rq.bready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge clock_i);
			if (rs.awready) rq.awvalid <= 1'b0;
			if (rs.wready) rq.wvalid <= 1'b0;
			if (rs.bvalid) break;
		end
		chk(rs.bresp, n < 64 ? e : 2'h3);
		rq.bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		int n;
		@(posedge clock_i);
		rq.araddr <= a;
		rq.arvalid <= 1'b1;
		rq.rready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge clock_i);
			if (rs.arready) rq.arvalid <= 1'b0;
			if (rs.rvalid) break;
		end
		chk(n < 64, 1'b1);
		d = rs.rdata;
		rp = rs.rresp;
		rq.rready <= 1'b0;
	endtask : rd
	////////////////////////////////////////////////////////////////////////
	initial begin
		rst_b_i = 1'b0;
		rq = '0;
		ai = '0;
		pn = '0;
		fault_cond_i = 1'b0;
		ms = {16'h3333, 16'h2222, 16'h1111, 16'h6666, 16'h5555, 16'h4444};
		repeat (10) @(posedge clock_i);
		chk({|sp, irq_o, power_en_o, fault_o}, 4'h0);
		rst_b_i <= 1'b1;
		foreach (rows[k]) begin
			rd(rows[k].a);
			chk({d, rp}, {rows[k].d, rows[k].r});
		end
		chk(ao, {16'h0, 16'h1111, 16'h2222});
		wr(8'h24, 32'h8000, 2'h0);
		repeat (3) @(posedge clock_i);
		chk(sp[1], 17'h0_8000);
		wr(8'h04, 32'h488, 2'h0);
		wr(8'h00, 32'h2, 2'h0);
		ai.present <= 4'h3;
		ai.data <= {32'h0, 32'hFFFF_FFFF};
		ai.valid <= 4'h1;
		@(posedge clock_i) ai.valid <= 4'h0;
		repeat (40) @(posedge clock_i);
		chk(sp[1] != 0 && sp[1] < 17'h0_4000, 1'b1);
		chk(sp[2], 17'h0_FFFF);
		chk(sp[3], 17'h1_1999);
		ai.data[1] <= 16'h0;
		repeat (20) @(posedge clock_i);
		chk(sp[3:2], {17'h0_199A, 17'h0});
		rd(8'h2C);
		chk(d, 32'h0000_199A);
		wr(8'h24, 32'h1234, 2'h2);
		rd(8'h18);
		chk(d[2], 1'b1);
		// floating input feeds zeros; the heavy filter needs a few hundred samples
		ai.present <= 4'h2;
		ai.valid <= 4'h1;
		repeat (512) @(posedge clock_i);
		ai.valid <= 4'h0;
		repeat (4) @(posedge clock_i);
		chk(sp[1], 17'h0);
		wr(8'h00, 32'h12, 2'h0);
		repeat (3) @(posedge clock_i);
		chk(ao, {16'h0, 16'h4444, 16'h5555});
		// interlock level first, so the reassignment does not trip
		ctl_u.level(2, 1'b1);
		repeat (4) @(posedge clock_i);
		wr(8'h0C, 32'h899, 2'h0);
		wr(8'h1C, 32'h1, 2'h0);
		ctl_u.level(0, 1'b1);
		repeat (4) @(posedge clock_i);
		chk(power_en_o, 1'b1);
		ctl_u.level(0, 1'b0);
		repeat (4) @(posedge clock_i);
		chk(power_en_o, 1'b0);
		ctl_u.level(0, 1'b1);
		ctl_u.level(2, 1'b0);
		repeat (5) @(posedge clock_i);
		chk({fault_o, power_en_o, irq_o}, 3'b101);
		ctl_u.pulse(1, 12);
		chk(fault_o, 1'b1);
		ctl_u.level(2, 1'b1);
		fault_cond_i <= 1'b1;
		ctl_u.pulse(1, 12);
		chk(fault_o, 1'b1);
		fault_cond_i <= 1'b0;
		ctl_u.pulse(1, 4);
		chk(fault_o, 1'b1);
		ctl_u.pulse(1, 12);
		chk({fault_o, power_en_o}, 2'b01);
		wr(8'h18, 32'h1F, 2'h0);
		chk(irq_o, 1'b0);
		ctl_u.level(3, 1'b1);
		repeat (4) @(posedge clock_i);
		pn.key_valid <= 1'b1;
		#1 chk({lock_o, key_ok}, 2'b10);
		@(posedge clock_i) pn.key_valid <= 1'b0;
		// panel write while locked is refused, after unlock it lands
		pn.wr_data <= 17'h0_0123;
		@(posedge clock_i) pn.wr <= 1'b1;
		@(posedge clock_i) pn.wr <= 1'b0;
		repeat (3) @(posedge clock_i);
		chk(sp[0], 17'h0);
		ctl_u.level(3, 1'b0);
		repeat (4) @(posedge clock_i);
		@(posedge clock_i) pn.wr <= 1'b1;
		@(posedge clock_i) pn.wr <= 1'b0;
		repeat (3) @(posedge clock_i);
		chk(sp[0], 17'h0_0123);
		wr(8'h10, 32'h1, 2'h0);
		rd(8'h14);
		chk(d[0], 1'b1);
		wr(8'h18, 32'h1F, 2'h0);
		wr(8'h10, 32'h3, 2'h0);
		rd(8'h14);
		chk(d[0], 1'b0);
		rd(8'h18);
		chk(d[4:3], 2'b01);
		conclude();
	end
	initial begin
		repeat (20000) @(posedge clock_i);
		num_errors++;
		conclude();
	end
endmodule : tb_top
